// ==== rtl/gpm_pkg.sv ====
/*
 * Constants and types shared by the pin mode / driver type port logic.
 * Assumes one 32-bit bus word per register and 16 pins per port.
 */
`default_nettype none
package gpm_pkg;
    localparam int PIN_COUNT = 16;
    localparam int PORT_COUNT = 3;
    localparam int MODE_W = 2;
    localparam int DATA_W = 32;
    localparam int LANE_COUNT = 4;
    localparam int LANE_W = 8;
    // Each port decodes a 1 KiB window
    localparam int WINDOW_BITS = 10;
    localparam logic [31:0] WINDOW_MASK = 32'h0000_03FF;
    localparam logic [31:0] PORT_BASE [PORT_COUNT] = '{32'h4002_0000, 32'h4002_0400,
        32'h4002_0800};
    localparam logic [31:0] MODE_RST [PORT_COUNT] = '{32'hA800_0000, 32'h0000_0280,
        32'h0000_0000};
    localparam logic [15:0] OTYPE_RST = 16'h0000;
    localparam logic [15:0] OTYPE_UPPER_READ = 16'h0000;
    localparam logic [WINDOW_BITS-1:0] OFS_PIN_MODE_SELECT = 10'h000;
    localparam logic [WINDOW_BITS-1:0] OFS_OUTPUT_DRIVER_TYPE = 10'h004;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_INPUT = 2'h0,
        MODE_OUTPUT = 2'h1,
        MODE_ALTERNATE = 2'h2,
        MODE_ANALOG = 2'h3
    } gpm_mode_e;

    localparam logic DRV_PUSH_PULL = 1'b0;
    localparam logic DRV_OPEN_DRAIN = 1'b1;

    typedef struct packed {
        logic [DATA_W-1:0] pinModeSelect;
        logic [PIN_COUNT-1:0] outputDriverType;
        logic [DATA_W-1:0] readData;
        logic readValid;
    } gpm_regs_s;

    typedef struct packed {
        logic [PIN_COUNT-1:0] padOut;
        logic [PIN_COUNT-1:0] padOe;
        logic [PIN_COUNT-1:0] inputValue;
        logic [PIN_COUNT-1:0] triggerEnable;
    } gpm_pad_s;
endpackage
`default_nettype wire

// ==== rtl/gpm_cfg_if.sv ====
/*
 * Carrier of the stored pin configuration from the register file to the pad logic.
 * Assumes both ends run on the same clock.
 */
`default_nettype none
interface gpm_cfg_if;
    import gpm_pkg::*;
    logic [DATA_W-1:0] pinModeField;
    logic [PIN_COUNT-1:0] drainTypeBit;
    modport reg_end (output pinModeField, output drainTypeBit);
    modport pad_end (input pinModeField, input drainTypeBit);
endinterface
`default_nettype wire

// ==== rtl/gpm_pad.sv ====
/*
 * Per-pin driver and input path, steered by mode field and drain type bit.
 * Assumes pad input is already synchronous to core_clk.
 */
`default_nettype none
module gpm_pad
    import gpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    gpm_cfg_if.pad_end cfg,
    input wire logic [PIN_COUNT-1:0] pinOutputValue,
    input wire logic [PIN_COUNT-1:0] altOutValue,
    input wire logic [PIN_COUNT-1:0] padIn,
    output logic [PIN_COUNT-1:0] padOut,
    output logic [PIN_COUNT-1:0] padOe,
    output logic [PIN_COUNT-1:0] pinInputValue,
    output logic [PIN_COUNT-1:0] triggerEnable
);
    gpm_pad_s padR;
    gpm_pad_s padNxt;
    logic [PIN_COUNT-1:0] outNxt;
    logic [PIN_COUNT-1:0] oeNxt;
    logic [PIN_COUNT-1:0] trigNxt;

    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
        gpm_mode_e mode;
        logic drive;
        logic value;
        assign mode = gpm_mode_e'(cfg.pinModeField[MODE_W*p +: MODE_W]);
        assign drive = (mode == MODE_OUTPUT) || (mode == MODE_ALTERNATE);
        assign value = (mode == MODE_ALTERNATE) ? altOutValue[p] : pinOutputValue[p];
        assign oeNxt[p] = drive && !(cfg.drainTypeBit[p] == DRV_OPEN_DRAIN && value);
        assign outNxt[p] = (cfg.drainTypeBit[p] == DRV_OPEN_DRAIN) ? 1'b0 : value;
        assign trigNxt[p] = (mode != MODE_ANALOG);
    end

    always_comb begin
        padNxt.padOut = outNxt;
        padNxt.padOe = oeNxt;
        padNxt.triggerEnable = trigNxt;
        padNxt.inputValue = padIn & trigNxt;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            padR <= '0;
        end else begin
            padR <= padNxt;
        end
    end

    assign padOut = padR.padOut;
    assign padOe = padR.padOe;
    assign pinInputValue = padR.inputValue;
    assign triggerEnable = padR.triggerEnable;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_pin0_analog;
        cfg.pinModeField[1:0] == MODE_ANALOG;
    endsequence
    sequence s_pin0_od_high;
        cfg.pinModeField[1:0] == MODE_OUTPUT && cfg.drainTypeBit[0] && pinOutputValue[0];
    endsequence
    sequence s_pin0_pp;
        cfg.pinModeField[1:0] == MODE_OUTPUT && !cfg.drainTypeBit[0];
    endsequence

    AST_ANALOG_ZERO: assert property (s_pin0_analog |=> !pinInputValue[0] && !padOe[0]
        && !triggerEnable[0])
        else $error("Analog pin drives or reads nonzero");
    AST_OPEN_DRAIN_RELEASE: assert property (s_pin0_od_high |=> !padOe[0])
        else $error("Open-drain pin driven on a one");
    AST_PUSH_PULL_DRIVE: assert property (s_pin0_pp |=> padOe[0]
        && padOut[0] == $past(pinOutputValue[0]))
        else $error("Push-pull pin not following output value");
endmodule
`default_nettype wire

// ==== rtl/gpm_port.sv ====
/*
 * One GPIO port: pin mode select and output driver type registers, with pad logic.
 * Assumes a simple on-chip bus: one-cycle select, byte enables set by the master
 * for the access size, read data one cycle later. Freeze bits come from the
 * freeze register outside this block.
 */
// How it works
// - Three instances exist, chosen by PORT_INDEX, decoding windows at 0x4002_0000, 0x4002_0400 and 0x4002_0800.
// - The pin mode register at offset 0x00 holds two bits per pin, pin n at bits 2n+1:2n.
// - A mode field of 00 means input, 01 output, 10 alternate function and 11 analog.
// - After reset the mode register holds 0xA800_0000, 0x0000_0280 or 0 for ports A, B, C.
// - Byte, half-word and word writes change only the enabled byte lanes.
// - The driver type register at offset 0x04 has one bit per pin in 15:0; 31:16 are reserved.
// - A driver type bit of 0 selects push-pull and 1 open-drain, push-pull after reset.
// - The driver type register resets to zero on every port.
// - Only bus writes change the mode and driver type fields.
// - Open-drain drives low on 0 and floats on 1; push-pull drives the value.
// - While freezeActive is high, pins with pinFreezeBit set ignore writes to their fields.
// - An analog pin reads 0 and has its driver and input trigger off.
`default_nettype none
module gpm_port
    import gpm_pkg::*;
#(
    parameter int PORT_INDEX = 0,
    parameter int PINS = PIN_COUNT
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic busSel,
    input wire logic busWrite,
    input wire logic [31:0] busAddr,
    input wire logic [LANE_COUNT-1:0] busByteEn,
    input wire logic [DATA_W-1:0] busWdata,
    output logic [DATA_W-1:0] busRdata,
    output logic busReadValid,
    input wire logic freezeActive,
    input wire logic [PIN_COUNT-1:0] pinFreezeBit,
    input wire logic [PIN_COUNT-1:0] pinOutputValue,
    input wire logic [PIN_COUNT-1:0] altOutValue,
    input wire logic [PIN_COUNT-1:0] padIn,
    output logic [PIN_COUNT-1:0] padOut,
    output logic [PIN_COUNT-1:0] padOe,
    output logic [PIN_COUNT-1:0] pinInputValue,
    output logic [PIN_COUNT-1:0] triggerEnable,
    output logic [DATA_W-1:0] pinModeSelect,
    output logic [PIN_COUNT-1:0] outputDriverType
);
    if (PORT_INDEX < 0 || PORT_INDEX >= PORT_COUNT) begin : g_bad_index
        $error("PORT_INDEX out of range");
    end
    if (PINS != PIN_COUNT) begin : g_bad_pins
        $error("Only 16 pins per port are supported");
    end

    // own base and own reset value
    localparam logic [31:0] MY_BASE = PORT_BASE[PORT_INDEX];
    localparam logic [31:0] MY_MODE_RST = MODE_RST[PORT_INDEX];

    gpm_regs_s regR;
    gpm_regs_s regNxt;
    gpm_cfg_if cfgBus ();

    logic hit;
    logic [WINDOW_BITS-1:0] offset;
    logic wrMode;
    logic wrType;
    logic rdStrobe;
    logic [DATA_W-1:0] laneMask;
    logic [DATA_W-1:0] modeFreeze;
    logic [DATA_W-1:0] modeWrMask;
    logic [PIN_COUNT-1:0] typeWrMask;

    assign hit = busSel && ((busAddr & ~WINDOW_MASK) == MY_BASE);
    assign offset = busAddr[WINDOW_BITS-1:0];
    assign wrMode = hit && busWrite && (offset == OFS_PIN_MODE_SELECT);
    assign wrType = hit && busWrite && (offset == OFS_OUTPUT_DRIVER_TYPE);
    assign rdStrobe = hit && !busWrite;

    for (genvar l = 0; l < LANE_COUNT; l++) begin : g_lane
        assign laneMask[LANE_W*l +: LANE_W] = {LANE_W{busByteEn[l]}};
    end

    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_freeze
        assign modeFreeze[MODE_W*p +: MODE_W] = {MODE_W{freezeActive && pinFreezeBit[p]}};
    end

    assign modeWrMask = laneMask & ~modeFreeze;
    // upper half never written
    // Only lanes 0 and 1 reach the stored bits; lanes 2 and 3 fall away
    assign typeWrMask = laneMask[PIN_COUNT-1:0] & ~({PIN_COUNT{freezeActive}} & pinFreezeBit);

    always_comb begin
        regNxt = regR;
        if (wrMode) begin
            regNxt.pinModeSelect = (regR.pinModeSelect & ~modeWrMask) |
                (busWdata & modeWrMask);
        end
        if (wrType) begin
            // one bit per pin in 15:0
            regNxt.outputDriverType = (regR.outputDriverType & ~typeWrMask) |
                (busWdata[PIN_COUNT-1:0] & typeWrMask);
        end
        regNxt.readValid = rdStrobe;
        regNxt.readData = UNMAPPED_READ;
        if (rdStrobe) begin
            // Narrow reads still return the whole word
            unique case (offset)
                OFS_PIN_MODE_SELECT: regNxt.readData = regR.pinModeSelect;
                OFS_OUTPUT_DRIVER_TYPE: regNxt.readData = {OTYPE_UPPER_READ,
                    regR.outputDriverType};
                default: regNxt.readData = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            regR.pinModeSelect <= MY_MODE_RST;
            regR.outputDriverType <= OTYPE_RST;
            regR.readData <= UNMAPPED_READ;
            regR.readValid <= 1'b0;
        end else begin
            regR <= regNxt;
        end
    end

    assign busRdata = regR.readData;
    assign busReadValid = regR.readValid;
    assign pinModeSelect = regR.pinModeSelect;
    assign outputDriverType = regR.outputDriverType;
    assign cfgBus.pinModeField = regR.pinModeSelect;
    assign cfgBus.drainTypeBit = regR.outputDriverType;

    gpm_pad u_pad (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .cfg(cfgBus),
        .pinOutputValue(pinOutputValue),
        .altOutValue(altOutValue),
        .padIn(padIn),
        .padOut(padOut),
        .padOe(padOe),
        .pinInputValue(pinInputValue),
        .triggerEnable(triggerEnable)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_full_mode_write;
        wrMode && busByteEn == 4'hF && !freezeActive;
    endsequence
    sequence s_idle_bus;
        !(hit && busWrite);
    endsequence
    sequence s_mode_read;
        rdStrobe && offset == OFS_PIN_MODE_SELECT;
    endsequence
    sequence s_unmapped_read;
        rdStrobe && offset != OFS_PIN_MODE_SELECT && offset != OFS_OUTPUT_DRIVER_TYPE;
    endsequence
    sequence s_full_type_write;
        wrType && busByteEn[1:0] == 2'h3 && !freezeActive;
    endsequence
    // Read answer is a one-cycle pulse; a stale valid would be taken twice
    sequence s_no_read;
        !rdStrobe;
    endsequence

    AST_RESET_VALUES: assert property (@(posedge core_clk) disable iff (1'b0)
        !reset_n |=> pinModeSelect == MY_MODE_RST && outputDriverType == OTYPE_RST)
        else $error("Wrong register values after reset");
    AST_WORD_WRITE: assert property (s_full_mode_write |=> pinModeSelect == $past(busWdata))
        else $error("Word write to mode register not stored");
    AST_LANE_KEEP: assert property (wrMode && !busByteEn[0] |=>
        pinModeSelect[7:0] == $past(pinModeSelect[7:0]))
        else $error("Disabled byte lane changed");
    AST_LANE_TAKE: assert property (wrType && busByteEn[1] && !freezeActive |=>
        outputDriverType[15:8] == $past(busWdata[15:8]))
        else $error("Enabled lane of driver type not stored");
    AST_NO_HW_CHANGE: assert property (s_idle_bus |=> $stable(pinModeSelect)
        && $stable(outputDriverType))
        else $error("Configuration changed without a write");
    AST_FREEZE_HOLD: assert property (hit && busWrite && freezeActive && pinFreezeBit[0]
        |=> pinModeSelect[1:0] == $past(pinModeSelect[1:0])
        && outputDriverType[0] == $past(outputDriverType[0]))
        else $error("Frozen pin configuration changed");
    AST_UPPER_ZERO: assert property (rdStrobe && offset == OFS_OUTPUT_DRIVER_TYPE
        |=> busReadValid && busRdata[31:16] == OTYPE_UPPER_READ
        && busRdata[15:0] == $past(outputDriverType))
        else $error("Driver type read back wrong");
    AST_MODE_READ: assert property (s_mode_read
        |=> busReadValid && busRdata == $past(pinModeSelect))
        else $error("Mode read not answered");
    AST_UNMAPPED_READ: assert property (s_unmapped_read
        |=> busReadValid && busRdata == UNMAPPED_READ)
        else $error("Unmapped read not answered with zero");
    AST_READ_PULSE: assert property (s_no_read
        |=> !busReadValid && busRdata == UNMAPPED_READ)
        else $error("Read answer without a read");
    AST_TYPE_WORD_WRITE: assert property (s_full_type_write
        |=> outputDriverType == $past(busWdata[PIN_COUNT-1:0]))
        else $error("Driver type write not stored");
endmodule
`default_nettype wire

// ==== test/gpm_pin_model.sv ====
/*
 * Far-side model of the pads of one port: resolves the wire level.
 * Assumes a weak pull-up on every pad and no other external driver.
 */
`default_nettype none
module gpm_pin_model
    import gpm_pkg::*;
(
    input wire logic [PIN_COUNT-1:0] padOut,
    input wire logic [PIN_COUNT-1:0] padOe,
    output logic [PIN_COUNT-1:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pad floats
    // Pull-up, so a released open-drain line reads 1, never a stale value
    assign padIn = (padOut & padOe) | ~padOe;
endmodule
`default_nettype wire

// ==== test/tb.sv ====
/*
 * Self-checking bench for three port instances sharing one register bus.
 * Assumes the one-cycle select and one-cycle read latency of the port's bus.
 */
`default_nettype none
module tb
    import gpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetN = 1'b0, busSel = 1'b0, busWrite = 1'b0, freezeActive = 1'b0;
    logic [31:0] busAddr = 32'h0, busWdata = 32'h0;
    logic [3:0] busByteEn = 4'h0;
    logic [15:0] pinFreezeBit = 16'h0, outVal = 16'h0, altVal = 16'h0;
    logic [31:0] rdata [3], modeOut [3];
    logic rvalid [3];
    logic [15:0] typeOut [3], padOut [3], padOe [3], padIn [3], pinIn [3], trig [3];
    logic [31:0] modes [5] = '{32'h0000_0000, 32'h5555_5555, 32'hAAAA_AAAA, 32'hFFFF_FFFF,
        32'hD5A5_1B6C};
    int nErrors = 0, compares = 0;

    always #5 clk = ~clk;

    for (genvar p = 0; p < 3; p++) begin : g
        gpm_port #(.PORT_INDEX(p), .PINS(16)) dut (.core_clk(clk), .reset_n(resetN),
            .busSel(busSel), .busWrite(busWrite), .busAddr(busAddr), .busByteEn(busByteEn),
            .busWdata(busWdata), .busRdata(rdata[p]), .busReadValid(rvalid[p]),
            .freezeActive(freezeActive), .pinFreezeBit(pinFreezeBit),
            .pinOutputValue(outVal), .altOutValue(altVal), .padIn(padIn[p]),
            .padOut(padOut[p]), .padOe(padOe[p]), .pinInputValue(pinIn[p]),
            .triggerEnable(trig[p]), .pinModeSelect(modeOut[p]), .outputDriverType(typeOut[p]));
        gpm_pin_model pins (.padOut(padOut[p]), .padOe(padOe[p]), .padIn(padIn[p]));
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            nErrors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One-cycle select, driven between rising edges
    task automatic acc(input int p, input logic [9:0] ofs, input logic w, input logic [3:0] be,
            input logic [31:0] d);
        @(negedge clk);
        busSel = 1'b1;
        busWrite = w;
        busAddr = PORT_BASE[p] | {22'h0, ofs};
        busByteEn = be;
        busWdata = d;
        @(negedge clk);
        busSel = 1'b0;
    endtask

    task automatic wr(input int p, input logic [9:0] ofs, input logic [3:0] be,
            input logic [31:0] d);
        acc(p, ofs, 1'b1, be, d);
    endtask

    task automatic rd(input int p, input logic [9:0] ofs, input logic [31:0] exp);
        acc(p, ofs, 1'b0, 4'hF, 32'h0);
        chk({31'h0, rvalid[p]}, 32'h1);
        chk(rdata[p], exp);
    endtask

    task automatic padchk(input int p, input logic [31:0] m, input logic [15:0] t);
        logic [15:0] eOe, eOut, eIn, eTrig;
        logic [1:0] md;
        logic src;
        for (int i = 0; i < 16; i++) begin
            md = m[2*i+:2];
            src = (md == MODE_ALTERNATE) ? altVal[i] : outVal[i];
            eOe[i] = (md == MODE_OUTPUT || md == MODE_ALTERNATE) && !(t[i] && src);
            eOut[i] = eOe[i] && src;
            eTrig[i] = (md != MODE_ANALOG);
            eIn[i] = eTrig[i] && (eOe[i] ? src : 1'b1);
        end
        chk({16'h0, padOe[p]}, {16'h0, eOe});
        chk({16'h0, padOut[p] & eOe}, {16'h0, eOut});
        chk({16'h0, pinIn[p]}, {16'h0, eIn});
        chk({16'h0, trig[p]}, {16'h0, eTrig});
    endtask

    initial begin
        repeat (4) @(negedge clk);
        resetN = 1'b1;
        for (int p = 0; p < 3; p++) begin
            rd(p, 10'h000, MODE_RST[p]);
            rd(p, 10'h004, 32'h0);
        end
        repeat (2) @(negedge clk);
        padchk(2, MODE_RST[2], 16'h0);
        rd(2, 10'h010, 32'h0);
        // Byte then half-word into a cleared register
        wr(2, 10'h000, 4'hF, 32'h0);
        wr(2, 10'h000, 4'h4, 32'hAAAA_55AA);
        wr(2, 10'h000, 4'h3, 32'h1234_5678);
        rd(2, 10'h000, 32'h00AA_5678);
        rd(0, 10'h000, MODE_RST[0]);
        chk(modeOut[1], MODE_RST[1]);
        wr(2, 10'h004, 4'hF, 32'hFFFF_0FF0);
        rd(2, 10'h004, 32'h0000_0FF0);
        chk({16'h0, typeOut[2]}, 32'h0000_0FF0);
        outVal = 16'hA5C3;
        altVal = 16'h3C96;
        for (int k = 0; k < 5; k++) begin
            wr(2, 10'h000, 4'hF, modes[k]);
            repeat (3) @(negedge clk);
            padchk(2, modes[k], 16'h0FF0);
        end
        freezeActive = 1'b1;
        pinFreezeBit = 16'h00FF;
        wr(2, 10'h000, 4'hF, 32'h0);
        wr(2, 10'h004, 4'hF, 32'h0);
        repeat (5) @(negedge clk);
        rd(2, 10'h000, 32'h0000_1B6C);
        rd(2, 10'h004, 32'h0000_00F0);
        pinFreezeBit = 16'hFFFF;
        freezeActive = 1'b0;
        wr(2, 10'h000, 4'hF, 32'h0);
        rd(2, 10'h000, 32'h0);
        // Dirty port A so the second reset has something to undo
        wr(0, 10'h000, 4'hF, 32'h1234_5678);
        rd(0, 10'h000, 32'h1234_5678);
        wr(0, 10'h004, 4'hF, 32'h0000_FFFF);
        rd(0, 10'h004, 32'h0000_FFFF);
        // Reset again in mid-run
        resetN = 1'b0;
        @(negedge clk);
        resetN = 1'b1;
        for (int p = 0; p < 3; p++) begin
            rd(p, 10'h000, MODE_RST[p]);
            rd(p, 10'h004, 32'h0);
        end
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(negedge clk);
        nErrors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
